/* File: design/sbfo_regs.svh */
`ifndef SBFO_REGS_SVH
`define SBFO_REGS_SVH

// status register bit positions
`define SBFO_FLAG_C 3'd0
`define SBFO_FLAG_Z 3'd1
`define SBFO_FLAG_N 3'd2
`define SBFO_FLAG_V 3'd3
`define SBFO_FLAG_S 3'd4
`define SBFO_FLAG_H 3'd5
`define SBFO_FLAG_T 3'd6
`define SBFO_FLAG_I 3'd7

// reset values of the result registers
`define SBFO_RESULT_RST 8'h00
`define SBFO_STATUS_RST 8'h00

// latency of every operation, in clock cycles
`define SBFO_OP_CYCLES 1

`endif

/* File: design/sbfo_pkg.sv */
package sbfo_pkg;

  // operation codes presented by the instruction decoder
  typedef enum logic [4:0] {
    SBFO_OP_NONE,
    SBFO_OP_SHIFT_LEFT_LOGICAL,
    SBFO_OP_SHIFT_RIGHT_LOGICAL,
    SBFO_OP_ROTATE_LEFT_CARRY,
    SBFO_OP_ROTATE_RIGHT_CARRY,
    SBFO_OP_SHIFT_RIGHT_ARITHMETIC,
    SBFO_OP_NIBBLE_EXCHANGE,
    SBFO_OP_STATUS_BIT_SET,
    SBFO_OP_STATUS_BIT_CLEAR,
    SBFO_OP_BIT_STORE_TO_FLAG,
    SBFO_OP_BIT_LOAD_FROM_FLAG,
    SBFO_OP_CARRY_SET,
    SBFO_OP_CARRY_CLEAR,
    SBFO_OP_NEGATIVE_SET,
    SBFO_OP_NEGATIVE_CLEAR,
    SBFO_OP_ZERO_SET
  } sbfo_op_e;

  typedef logic [7:0] sbfo_byte_t;
  typedef logic [2:0] sbfo_index_t;

endpackage

/* File: design/sbfo_shifter.sv */
`timescale 1ns/100ps
`include "sbfo_regs.svh"

// combinational shift, rotate and swap unit with its flag results
module sbfo_shifter (
  // operation and operands
  input wire sbfo_pkg::sbfo_op_e op,
  input wire sbfo_pkg::sbfo_byte_t operand,
  input wire logic carry_in,
  // results
  output sbfo_pkg::sbfo_byte_t result,
  output logic carry_out,
  output logic zero_out,
  output logic negative_out,
  output logic overflow_out,
  output logic sign_out,
  output logic flags_valid
);

  // data path and carry out per operation
  always_comb begin
    result = operand;
    carry_out = carry_in;
    flags_valid = 1'b1;
    case (op)
      sbfo_pkg::SBFO_OP_SHIFT_LEFT_LOGICAL: begin
        result = {operand[6:0], 1'b0};
        carry_out = operand[7];
      end
      sbfo_pkg::SBFO_OP_SHIFT_RIGHT_LOGICAL: begin
        result = {1'b0, operand[7:1]};
        carry_out = operand[0];
      end
      sbfo_pkg::SBFO_OP_ROTATE_LEFT_CARRY: begin
        result = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      sbfo_pkg::SBFO_OP_ROTATE_RIGHT_CARRY: begin
        result = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      sbfo_pkg::SBFO_OP_SHIFT_RIGHT_ARITHMETIC: begin
        result = {operand[7], operand[7:1]};
        carry_out = operand[0];
      end
      sbfo_pkg::SBFO_OP_NIBBLE_EXCHANGE: begin
        result = {operand[3:0], operand[7:4]};
        flags_valid = 1'b0;
      end
      default: begin
        flags_valid = 1'b0;
      end
    endcase
  end

  // flag results: overflow is negative xor carry after the shift
  assign zero_out = (result == 8'h00);
  assign negative_out = result[7];
  assign overflow_out = negative_out ^ carry_out;
  assign sign_out = negative_out ^ overflow_out;

endmodule

/* File: design/sbfo_core.sv */
`timescale 1ns/100ps
`include "sbfo_regs.svh"

// What this block does
// - shift left logical, zero into bit 0
// - shift right logical, zero into bit 7
// - rotate left through carry flag
// - rotate right through carry flag
// - arithmetic shift right keeps sign bit
// - swap nibbles, no flag changes
// - set or clear one indexed status bit
// - copy register bit into transfer flag
// - load transfer flag into register bit
// - set or clear carry flag only
// - set or clear negative flag only
// - set zero flag only
// - every operation completes in one cycle
module sbfo_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // request from the instruction decoder
  input wire logic op_valid,
  input wire sbfo_pkg::sbfo_op_e op,
  input wire sbfo_pkg::sbfo_byte_t operand,
  input wire sbfo_pkg::sbfo_index_t bit_index,
  // current status register contents
  input wire sbfo_pkg::sbfo_byte_t status_in,
  // register file write-back
  output sbfo_pkg::sbfo_byte_t result,
  output logic result_write,
  // status register write-back
  output sbfo_pkg::sbfo_byte_t status_out,
  output logic status_write,
  // completion
  output logic op_done
);

  sbfo_pkg::sbfo_byte_t shift_result;
  logic shift_carry;
  logic shift_zero;
  logic shift_negative;
  logic shift_overflow;
  logic shift_sign;
  logic shift_flags_valid;
  sbfo_pkg::sbfo_byte_t next_result;
  sbfo_pkg::sbfo_byte_t next_status;
  logic next_result_write;
  logic next_status_write;
  sbfo_pkg::sbfo_byte_t index_mask;
  sbfo_pkg::sbfo_byte_t bit_load_value;
  sbfo_pkg::sbfo_byte_t shift_status;
  logic selected_bit;
  logic op_writes_result;
  logic op_writes_status;

  // shift, rotate and swap data path
  sbfo_shifter u_shifter (
    .op(op),
    .operand(operand),
    .carry_in(status_in[`SBFO_FLAG_C]),
    .result(shift_result),
    .carry_out(shift_carry),
    .zero_out(shift_zero),
    .negative_out(shift_negative),
    .overflow_out(shift_overflow),
    .sign_out(shift_sign),
    .flags_valid(shift_flags_valid)
  );

  // one-hot mask of the selected bit, and the operand with that bit loaded
  for (genvar g = 0; g < 8; g++) begin : g_bit
    assign index_mask[g] = (bit_index == 3'(g));
    assign bit_load_value[g] = index_mask[g] ? status_in[`SBFO_FLAG_T] : operand[g];
  end

  // register bit picked for the transfer flag
  assign selected_bit = |(operand & index_mask);

  // status after a shift: listed flags and sign replaced, the rest kept
  always_comb begin
    shift_status = status_in;
    shift_status[`SBFO_FLAG_C] = shift_carry;
    shift_status[`SBFO_FLAG_Z] = shift_zero;
    shift_status[`SBFO_FLAG_N] = shift_negative;
    shift_status[`SBFO_FLAG_V] = shift_overflow;
    shift_status[`SBFO_FLAG_S] = shift_sign;
  end

  // operation classes: which write-back each operation asks for
  always_comb begin
    op_writes_result = 1'b0;
    op_writes_status = 1'b0;
    case (op)
      // shifts and rotates write the register and the flags
      sbfo_pkg::SBFO_OP_SHIFT_LEFT_LOGICAL,
      sbfo_pkg::SBFO_OP_SHIFT_RIGHT_LOGICAL,
      sbfo_pkg::SBFO_OP_ROTATE_LEFT_CARRY,
      sbfo_pkg::SBFO_OP_ROTATE_RIGHT_CARRY,
      sbfo_pkg::SBFO_OP_SHIFT_RIGHT_ARITHMETIC: begin
        op_writes_result = 1'b1;
        op_writes_status = shift_flags_valid;
      end
      // swap and bit load touch the register only
      sbfo_pkg::SBFO_OP_NIBBLE_EXCHANGE,
      sbfo_pkg::SBFO_OP_BIT_LOAD_FROM_FLAG: begin
        op_writes_result = 1'b1;
      end
      // bit, transfer flag and single flag operations touch the status only
      sbfo_pkg::SBFO_OP_STATUS_BIT_SET,
      sbfo_pkg::SBFO_OP_STATUS_BIT_CLEAR,
      sbfo_pkg::SBFO_OP_BIT_STORE_TO_FLAG,
      sbfo_pkg::SBFO_OP_CARRY_SET,
      sbfo_pkg::SBFO_OP_CARRY_CLEAR,
      sbfo_pkg::SBFO_OP_NEGATIVE_SET,
      sbfo_pkg::SBFO_OP_NEGATIVE_CLEAR,
      sbfo_pkg::SBFO_OP_ZERO_SET: begin
        op_writes_status = 1'b1;
      end
      // no operation: nothing written
      default: begin
        op_writes_result = 1'b0;
      end
    endcase
  end

  // next register value; the operand passes when nothing is written
  always_comb begin
    next_result = operand;
    if (op_valid) begin
      case (op)
        sbfo_pkg::SBFO_OP_SHIFT_LEFT_LOGICAL: next_result = shift_result;
        sbfo_pkg::SBFO_OP_SHIFT_RIGHT_LOGICAL: next_result = shift_result;
        sbfo_pkg::SBFO_OP_ROTATE_LEFT_CARRY: next_result = shift_result;
        sbfo_pkg::SBFO_OP_ROTATE_RIGHT_CARRY: next_result = shift_result;
        sbfo_pkg::SBFO_OP_SHIFT_RIGHT_ARITHMETIC: next_result = shift_result;
        sbfo_pkg::SBFO_OP_NIBBLE_EXCHANGE: next_result = shift_result;
        sbfo_pkg::SBFO_OP_BIT_LOAD_FROM_FLAG: next_result = bit_load_value;
        default: next_result = operand;
      endcase
    end
  end

  // next status value; every flag not named by the operation is kept
  always_comb begin
    next_status = status_in;
    if (op_valid) begin
      case (op)
        sbfo_pkg::SBFO_OP_SHIFT_LEFT_LOGICAL: next_status = shift_status;
        sbfo_pkg::SBFO_OP_SHIFT_RIGHT_LOGICAL: next_status = shift_status;
        sbfo_pkg::SBFO_OP_ROTATE_LEFT_CARRY: next_status = shift_status;
        sbfo_pkg::SBFO_OP_ROTATE_RIGHT_CARRY: next_status = shift_status;
        sbfo_pkg::SBFO_OP_SHIFT_RIGHT_ARITHMETIC: next_status = shift_status;
        sbfo_pkg::SBFO_OP_STATUS_BIT_SET: next_status = status_in | index_mask;
        sbfo_pkg::SBFO_OP_STATUS_BIT_CLEAR: next_status = status_in & ~index_mask;
        sbfo_pkg::SBFO_OP_BIT_STORE_TO_FLAG: begin
          next_status[`SBFO_FLAG_T] = selected_bit;
        end
        sbfo_pkg::SBFO_OP_CARRY_SET: begin
          next_status[`SBFO_FLAG_C] = 1'b1;
        end
        sbfo_pkg::SBFO_OP_CARRY_CLEAR: begin
          next_status[`SBFO_FLAG_C] = 1'b0;
        end
        sbfo_pkg::SBFO_OP_NEGATIVE_SET: begin
          next_status[`SBFO_FLAG_N] = 1'b1;
        end
        sbfo_pkg::SBFO_OP_NEGATIVE_CLEAR: begin
          next_status[`SBFO_FLAG_N] = 1'b0;
        end
        sbfo_pkg::SBFO_OP_ZERO_SET: begin
          next_status[`SBFO_FLAG_Z] = 1'b1;
        end
        default: next_status = status_in;
      endcase
    end
  end

  // write strobes only for a valid request
  assign next_result_write = op_valid && op_writes_result;
  assign next_status_write = op_valid && op_writes_status;

  // data outputs registered, one cycle after the request
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result <= `SBFO_RESULT_RST;
      status_out <= `SBFO_STATUS_RST;
    end else begin
      result <= next_result;
      status_out <= next_status;
    end
  end

  // write strobes and completion pulse
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result_write <= 1'b0;
      status_write <= 1'b0;
      op_done <= 1'b0;
    end else begin
      result_write <= next_result_write;
      status_write <= next_status_write;
      op_done <= op_valid && (op != sbfo_pkg::SBFO_OP_NONE);
    end
  end

endmodule

/* File: dv/sbfo_core_chk.sv */
`timescale 1ns/100ps
// port checks for the shift, bit and flag slice
module sbfo_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic op_valid,
  input wire sbfo_pkg::sbfo_op_e op,
  input wire sbfo_pkg::sbfo_byte_t operand,
  input wire sbfo_pkg::sbfo_index_t bit_index,
  input wire sbfo_pkg::sbfo_byte_t status_in,
  input wire sbfo_pkg::sbfo_byte_t result,
  input wire logic result_write,
  input wire sbfo_pkg::sbfo_byte_t status_out,
  input wire logic status_write,
  input wire logic op_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // answers one cycle after a request, none without one
  property p_done;
    op_valid && op != sbfo_pkg::SBFO_OP_NONE |=> op_done;
  endproperty
  a_done: assert property (p_done) else $error("late");
  property p_quiet;
    !op_valid |=> !op_done && !result_write && !status_write;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray");
  // register results against the operand and carry, and the status bit set against the bit index
  property p_lsl;
    op_valid && op == sbfo_pkg::SBFO_OP_SHIFT_LEFT_LOGICAL |=> result == $past(operand) << 1;
  endproperty
  a_lsl: assert property (p_lsl) else $error("lsl");
  property p_rol;
    op_valid && op == sbfo_pkg::SBFO_OP_ROTATE_LEFT_CARRY
      |=> result == ($past(operand) << 1 | $past(status_in) & 8'h01);
  endproperty
  a_rol: assert property (p_rol) else $error("rol");
  property p_ror;
    op_valid && op == sbfo_pkg::SBFO_OP_ROTATE_RIGHT_CARRY
      |=> result == ($past(operand) >> 1 | $past(status_in) << 7);
  endproperty
  a_ror: assert property (p_ror) else $error("ror");
  property p_asr;
    op_valid && op == sbfo_pkg::SBFO_OP_SHIFT_RIGHT_ARITHMETIC
      |=> result == ($past(operand) >> 1 | $past(operand) & 8'h80);
  endproperty
  a_asr: assert property (p_asr) else $error("asr");
  property p_swap;
    op_valid && op == sbfo_pkg::SBFO_OP_NIBBLE_EXCHANGE
      |=> !status_write && result == ($past(operand) << 4 | $past(operand) >> 4);
  endproperty
  a_swap: assert property (p_swap) else $error("swap");
  property p_status_bit_set;
    op_valid && op == sbfo_pkg::SBFO_OP_STATUS_BIT_SET
      |=> status_out == ($past(status_in) | 8'h01 << $past(bit_index));
  endproperty
  a_status_bit_set: assert property (p_status_bit_set) else $error("status_bit_set");
endmodule
bind sbfo_core sbfo_chk u_chk (.*);

/* File: dv/sbfo_status_model.sv */
`timescale 1ns/100ps
// status register beside the core: preloadable, takes write-backs
module sbfo_status_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic load,
  input wire sbfo_pkg::sbfo_byte_t load_val,
  input wire sbfo_pkg::sbfo_byte_t status_out,
  input wire logic status_write,
  output sbfo_pkg::sbfo_byte_t status_in
);
  // preload wins over write-back
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) status_in <= 8'h00;
    else if (load) status_in <= load_val;
    else if (status_write) status_in <= status_out;
  end
endmodule

/* File: dv/sbfo_core_bench.sv */
`timescale 1ns/100ps
module sbfo_core_bench;
  typedef struct {
    sbfo_pkg::sbfo_byte_t d, s, r, t;
    sbfo_pkg::sbfo_index_t i;
  } sbfo_row_s;
  logic clk_sys = 1'h0, reset = 1'h1, op_valid = 1'h0, load = 1'h0;
  logic result_write, status_write, op_done, wr, ws;
  sbfo_pkg::sbfo_op_e op = sbfo_pkg::SBFO_OP_NONE;
  sbfo_pkg::sbfo_byte_t operand = 8'h00, load_val = 8'h00, status_in, result, status_out;
  sbfo_pkg::sbfo_index_t bit_index = 3'h0;
  int n_mismatch = 0, n_checks = 0;
  sbfo_row_s rows [16];
  always #25 clk_sys = ~clk_sys;
  sbfo_core u_sbfo_core (.*);
  sbfo_status_model u_sbfo_status_model (.*);
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [7:0] strobes;
    return {5'h00, op_done, result_write, status_write};
  endfunction
  // rows: operand, status before, result, status after, bit index
  initial begin
    rows = '{'{8'h55, 8'h00, 8'h00, 8'h00, 3'h0}, '{8'h81, 8'h00, 8'h02, 8'h19, 3'h0},
      '{8'h01, 8'hE0, 8'h00, 8'hFB, 3'h0}, '{8'h80, 8'h01, 8'h01, 8'h19, 3'h0},
      '{8'h02, 8'h01, 8'h81, 8'h0C, 3'h0}, '{8'h81, 8'h00, 8'hC0, 8'h15, 3'h0},
      '{8'h3C, 8'h5A, 8'hC3, 8'h00, 3'h0}, '{8'h00, 8'h00, 8'h00, 8'h80, 3'h7},
      '{8'h00, 8'hFF, 8'h00, 8'hFE, 3'h0}, '{8'hDF, 8'hFF, 8'h00, 8'hBF, 3'h5},
      '{8'hF0, 8'h40, 8'hF8, 8'h00, 3'h3}, '{8'h00, 8'hFE, 8'h00, 8'hFF, 3'h0},
      '{8'h00, 8'hFF, 8'h00, 8'hFE, 3'h0}, '{8'h00, 8'hFB, 8'h00, 8'hFF, 3'h0},
      '{8'h00, 8'hFF, 8'h00, 8'hFB, 3'h0}, '{8'h00, 8'hFD, 8'h00, 8'hFF, 3'h0}};
    repeat (5) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    #1 check("strobes", strobes(), 8'h00);
    for (int k = 0; k < 16; k++) begin
      load <= 1'h1;
      load_val <= rows[k].s;
      @(posedge clk_sys);
      load <= 1'h0;
      op_valid <= 1'h1;
      op <= sbfo_pkg::sbfo_op_e'(5'(k));
      operand <= rows[k].d;
      bit_index <= rows[k].i;
      @(posedge clk_sys);
      op_valid <= 1'h0;
      wr = (k > 0 && k < 7) || k == 10;
      ws = k > 0 && k != 6 && k != 10;
      #1 check("strobes", strobes(), {5'h00, wr | ws, wr, ws});
      if (wr) check("result", result, rows[k].r);
      if (ws) check("status", status_out, rows[k].t);
      @(posedge clk_sys);
    end
    // back-to-back requests, then the code held with valid low
    op_valid <= 1'h1;
    op <= sbfo_pkg::SBFO_OP_SHIFT_LEFT_LOGICAL;
    operand <= 8'h40;
    @(posedge clk_sys);
    op <= sbfo_pkg::SBFO_OP_NIBBLE_EXCHANGE;
    operand <= 8'hA5;
    #1 check("result", result, 8'h80);
    check("status", status_out, 8'hEC);
    @(posedge clk_sys);
    op_valid <= 1'h0;
    #1 check("result", result, 8'h5A);
    @(posedge clk_sys);
    #1 check("strobes", strobes(), 8'h00);
    // reset in mid-run clears the outputs
    op_valid <= 1'h1;
    reset <= 1'h1;
    @(posedge clk_sys);
    #1 check("strobes", strobes(), 8'h00);
    check("result", result, 8'h00);
    // first request right at the first edge after release
    reset <= 1'h0;
    @(posedge clk_sys);
    #1 check("strobes", strobes(), 8'h06);
    check("result", result, 8'h5A);
    close_out();
  end
endmodule
